// >>> irq_ctl_params.svh
`ifndef IRQ_CTL_PARAMS_SVH
`define IRQ_CTL_PARAMS_SVH

// register byte addresses
`define ADDR_RISE_EN      16'hFF48
`define ADDR_FALL_EN      16'hFF49
`define ADDR_MASK_A       16'hFFE4
`define ADDR_MASK_B       16'hFFE5
`define ADDR_MASK_C       16'hFFE6
`define ADDR_PRIO_A       16'hFFE8
`define ADDR_PRIO_B       16'hFFE9
`define ADDR_PRIO_C       16'hFFEA
`define ADDR_STATUS_WORD  16'hFF1E

// reset values
`define RST_EDGE_EN       8'h00
`define RST_MASK          8'hFF
`define RST_PRIO          8'hFF
`define RST_STATUS_WORD   8'h02

// field positions
`define SW_IE_BIT         3'h7
`define SW_ISP_BIT        3'h1
`define RISE_EN_LSB       4
`define WDOG_MASK_BIT     3'h0
`define EXT_SRC_BASE      1

// sizes
`define NUM_SRC           24
`define NUM_EXT           4

`endif

// >>> irq_ctl_pkg.sv
package irq_ctl_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [4:0] src_idx_t;

  // valid edge choice, encoded {rise_en, fall_en}, both active high
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_RISE = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;

endpackage

// >>> ext_edge_if.sv
`timescale 1ns/1ps
interface ext_edge_if;
  logic [3:0] pin;
  logic [3:0] rise_en;
  logic [3:0] fall_en;
  wire  [3:0] hit;

  modport ctl (output pin, output rise_en, output fall_en, input hit);
  modport det (input pin, input rise_en, input fall_en, output hit);
endinterface

// >>> ext_edge_detect.sv
`timescale 1ns/1ps
module ext_edge_detect #(
  parameter int CH = 0
) (
  input wire logic clk,
  input wire logic resetn,
  ext_edge_if.det  eif
);

  logic                  s1_r;
  logic                  s2_r;
  logic                  s3_r;
  logic                  level_r;
  logic                  hit_r;
  irq_ctl_pkg::edge_sel_t sel;
  logic                  qualify;

  ////////////////////////////////////////////////////////////////////////////
  // three-stage synchroniser; only s2 reads s1
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= eif.pin[CH];
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge choice from the two enable bits
  always_comb begin
    sel = irq_ctl_pkg::edge_sel_t'({eif.rise_en[CH], eif.fall_en[CH]});
    unique case (sel)
      irq_ctl_pkg::EDGE_NONE: qualify = 1'b0;
      irq_ctl_pkg::EDGE_FALL: qualify = ~s2_r;
      irq_ctl_pkg::EDGE_RISE: qualify = s2_r;
      irq_ctl_pkg::EDGE_BOTH: qualify = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // accepted level change gives one single-cycle hit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level_r <= 1'b0;
      hit_r   <= 1'b0;
    end else if ((s2_r == s3_r) && (s2_r != level_r)) begin
      level_r <= s2_r;
      hit_r   <= qualify;
    end else begin
      hit_r   <= 1'b0;
    end
  end

  assign eif.hit[CH] = hit_r;

endmodule

// >>> irq_ctl.sv
`timescale 1ns/1ps
`include "irq_ctl_params.svh"

// What this block does
// - a mask bit of 0 lets its source be serviced, 1 blocks it
// - three byte mask registers at FFE4H-FFE6H take bit or byte writes
// - first two mask registers also take one 16-bit word write
// - reset loads all mask registers with all ones
// - watchdog mask bit reads undefined while watchdog mode 1 runs
// - output level change on a shared port pin sets its request flag
// - priority registers take bit, byte, and combined word writes
// - reset loads all priority registers with all ones
// - rise and fall enable pair picks none, falling, rising or both edges
// - rise enables in bits 7-4 at FF48H, fall enables bits 3-0 at FF49H
// - edge pair n watches port 0 pin n and raises external request n
// - reset clears both edge enable registers
// - status word holds global enable and in-service priority flags
// - status word byte and bit access; enable/disable instructions set flag
// - acknowledge or break pushes status word and clears global enable
// - maskable acknowledge copies source priority into in-service flag
// - return and pop restore status word; push instruction pushes it
// - reset loads status word with 02H
// - request acknowledgeable when flagged and unmasked, taken when enabled
// - priority 0 is high; in-service 0 blocks low-priority requests
// - higher programmed priority wins; ties go to fixed default order
// - request flag clears on acknowledge and on reset
module irq_ctl (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [15:0] sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic        sfr_word,
  input  wire logic        sfr_bit,
  input  wire logic [2:0]  sfr_bit_idx,
  input  wire logic [15:0] sfr_wdata,
  output logic      [15:0] sfr_rdata,
  input  wire logic        ei_instr,
  input  wire logic        di_instr,
  input  wire logic        brk_instr,
  input  wire logic        return_from_int_instr_instr,
  input  wire logic        return_from_break_instr_instr,
  input  wire logic        pop_psw_instr,
  input  wire logic        push_psw_instr,
  input  wire logic [7:0]  psw_pop_data,
  input  wire logic        irq_ack,
  input  wire logic [23:0] periph_req,
  input  wire logic [3:0]  port0_pin,
  input  wire logic        wdog_mode1,
  output logic             irq_req,
  output logic      [4:0]  irq_src,
  output logic             irq_prio,
  output logic      [7:0]  status_word,
  output logic             psw_push_valid,
  output logic      [7:0]  psw_push_data,
  output logic      [23:0] request_flags
);

  irq_ctl_pkg::byte_t    int_mask_reg_a_r;
  irq_ctl_pkg::byte_t    int_mask_reg_b_r;
  irq_ctl_pkg::byte_t    int_mask_reg_c_r;
  irq_ctl_pkg::byte_t    prio_reg_a_r;
  irq_ctl_pkg::byte_t    prio_reg_b_r;
  irq_ctl_pkg::byte_t    prio_reg_c_r;
  logic [3:0]            rising_edge_enable_r;
  logic [3:0]            falling_edge_enable_r;
  irq_ctl_pkg::byte_t    status_word_r;
  logic [23:0]           request_flag_r;
  logic [23:0]           request_flag_nxt;
  logic [15:0]           sfr_rdata_r;
  logic                  irq_req_r;
  irq_ctl_pkg::src_idx_t irq_src_r;
  logic                  irq_prio_r;
  logic                  psw_push_valid_r;
  irq_ctl_pkg::byte_t    psw_push_data_r;
  irq_ctl_pkg::byte_t    rise_wr;
  irq_ctl_pkg::byte_t    fall_wr;

  // edge enable reset value split into its rise and fall halves
  localparam irq_ctl_pkg::byte_t EDGE_RST = `RST_EDGE_EN;

  logic [23:0]           int_mask_flag;
  logic [23:0]           prio_flag;
  logic [23:0]           ext_set;
  logic [15:0]           addr_hi;
  logic                  ack_ok;
  logic                  enter_isr;
  logic                  pop_any;
  logic                  hit_high;
  logic                  hit_low;
  irq_ctl_pkg::src_idx_t idx_high;
  irq_ctl_pkg::src_idx_t idx_low;
  logic                  irq_req_nxt;
  irq_ctl_pkg::src_idx_t irq_src_nxt;
  logic                  irq_prio_nxt;

  ext_edge_if eif ();

  ////////////////////////////////////////////////////////////////////////////
  // byte lane helpers

  assign addr_hi = sfr_addr + 16'h0001;

  // next value of one byte register after a bit, byte or word write
  function automatic irq_ctl_pkg::byte_t wr_byte(input irq_ctl_pkg::byte_t old_v,
                                                  input logic [15:0]       reg_a);
    irq_ctl_pkg::byte_t res;
    res = old_v;
    if (sfr_wr && (sfr_addr == reg_a)) begin
      if (sfr_bit) begin
        res[sfr_bit_idx] = sfr_wdata[0];
      end else begin
        res = sfr_wdata[7:0];
      end
    end else if (sfr_wr && sfr_word && !sfr_bit && (addr_hi == reg_a)) begin
      res = sfr_wdata[15:8];
    end
    return res;
  endfunction

  // read value of the byte register at one address
  function automatic irq_ctl_pkg::byte_t rd_byte(input logic [15:0] a);
    irq_ctl_pkg::byte_t res;
    res = 8'h00;
    unique case (a)
      `ADDR_RISE_EN:     res = {rising_edge_enable_r, 4'h0};
      `ADDR_FALL_EN:     res = {4'h0, falling_edge_enable_r};
      `ADDR_MASK_A: begin
        res = int_mask_reg_a_r;
        if (wdog_mode1) begin
          res[`WDOG_MASK_BIT] = 1'b0;
        end
      end
      `ADDR_MASK_B:      res = int_mask_reg_b_r;
      `ADDR_MASK_C:      res = int_mask_reg_c_r;
      `ADDR_PRIO_A:      res = prio_reg_a_r;
      `ADDR_PRIO_B:      res = prio_reg_b_r;
      `ADDR_PRIO_C:      res = prio_reg_c_r;
      `ADDR_STATUS_WORD: res = status_word_r;
      default:           res = 8'h00;
    endcase
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mask registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_mask_reg_a_r <= `RST_MASK;
      int_mask_reg_b_r <= `RST_MASK;
      int_mask_reg_c_r <= `RST_MASK;
    end else begin
      int_mask_reg_a_r <= wr_byte(int_mask_reg_a_r, `ADDR_MASK_A);
      int_mask_reg_b_r <= wr_byte(int_mask_reg_b_r, `ADDR_MASK_B);
      int_mask_reg_c_r <= wr_byte(int_mask_reg_c_r, `ADDR_MASK_C);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prio_reg_a_r <= `RST_PRIO;
      prio_reg_b_r <= `RST_PRIO;
      prio_reg_c_r <= `RST_PRIO;
    end else begin
      prio_reg_a_r <= wr_byte(prio_reg_a_r, `ADDR_PRIO_A);
      prio_reg_b_r <= wr_byte(prio_reg_b_r, `ADDR_PRIO_B);
      prio_reg_c_r <= wr_byte(prio_reg_c_r, `ADDR_PRIO_C);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge enable byte images after a write, stored bits picked below
  always_comb begin
    rise_wr = wr_byte({rising_edge_enable_r, 4'h0}, `ADDR_RISE_EN);
    fall_wr = wr_byte({4'h0, falling_edge_enable_r}, `ADDR_FALL_EN);
  end

  // edge enable registers; unused bits are not stored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rising_edge_enable_r  <= EDGE_RST[7:4];
      falling_edge_enable_r <= EDGE_RST[3:0];
    end else begin
      rising_edge_enable_r  <= rise_wr[7:4];
      falling_edge_enable_r <= fall_wr[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags by source, same bit order as the request flags
  assign int_mask_flag = {int_mask_reg_c_r, int_mask_reg_b_r, int_mask_reg_a_r};
  assign prio_flag     = {prio_reg_c_r, prio_reg_b_r, prio_reg_a_r};

  ////////////////////////////////////////////////////////////////////////////
  // external pin edge detection, one detector per pin
  assign eif.pin     = port0_pin;
  assign eif.rise_en = rising_edge_enable_r;
  assign eif.fall_en = falling_edge_enable_r;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_EXT; gi++) begin : g_ext
      ext_edge_detect #(
        .CH (gi)
      ) u_det (
        .clk    (clk),
        .resetn (resetn),
        .eif    (eif)
      );
    end
  endgenerate

  // external request n lands on source bit base+n
  assign ext_set = {20'h00000, eif.hit} << `EXT_SRC_BASE;

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge handshake qualifiers
  assign ack_ok    = irq_ack & irq_req_r;
  assign enter_isr = ack_ok | brk_instr;
  assign pop_any   = return_from_int_instr_instr | return_from_break_instr_instr | pop_psw_instr;

  ////////////////////////////////////////////////////////////////////////////
  // request flags: a new request wins over the acknowledge clear
  always_comb begin
    request_flag_nxt = request_flag_r;
    if (ack_ok) begin
      request_flag_nxt[irq_src_r] = 1'b0;
    end
    request_flag_nxt = request_flag_nxt | periph_req | ext_set;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      request_flag_r <= 24'h000000;
    end else begin
      request_flag_r <= request_flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word: hardware events over software access
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_word_r <= `RST_STATUS_WORD;
    end else if (enter_isr) begin
      status_word_r[`SW_IE_BIT] <= 1'b0;
      if (ack_ok) begin
        status_word_r[`SW_ISP_BIT] <= irq_prio_r;
      end
    end else if (pop_any) begin
      status_word_r <= psw_pop_data;
    end else if (ei_instr) begin
      status_word_r[`SW_IE_BIT] <= 1'b1;
    end else if (di_instr) begin
      status_word_r[`SW_IE_BIT] <= 1'b0;
    end else begin
      status_word_r <= wr_byte(status_word_r, `ADDR_STATUS_WORD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack push of the status word as it stood before the event
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      psw_push_valid_r <= 1'b0;
      psw_push_data_r  <= 8'h00;
    end else begin
      psw_push_valid_r <= enter_isr | push_psw_instr;
      if (enter_isr || push_psw_instr) begin
        psw_push_data_r <= status_word_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration: lowest index is the highest default priority
  always_comb begin
    hit_high = 1'b0;
    hit_low  = 1'b0;
    idx_high = 5'h00;
    idx_low  = 5'h00;
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (request_flag_r[i] && !int_mask_flag[i]) begin
        if (!prio_flag[i]) begin
          hit_high = 1'b1;
          idx_high = 5'(i);
        end else begin
          hit_low = 1'b1;
          idx_low = 5'(i);
        end
      end
    end
  end

  always_comb begin
    irq_src_nxt  = idx_low;
    irq_prio_nxt = 1'b1;
    irq_req_nxt  = 1'b0;
    if (hit_high) begin
      irq_src_nxt  = idx_high;
      irq_prio_nxt = 1'b0;
      irq_req_nxt  = 1'b1;
    end else if (hit_low && status_word_r[`SW_ISP_BIT]) begin
      irq_req_nxt  = 1'b1;
    end
    // global enable gates, and a taken request drops at once
    irq_req_nxt = irq_req_nxt & status_word_r[`SW_IE_BIT] & ~enter_isr;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_req_r  <= 1'b0;
      irq_src_r  <= 5'h00;
      irq_prio_r <= 1'b1;
    end else begin
      irq_req_r  <= irq_req_nxt;
      irq_src_r  <= irq_src_nxt;
      irq_prio_r <= irq_prio_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port, answered one cycle after the read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata_r <= 16'h0000;
    end else if (sfr_rd) begin
      if (sfr_word) begin
        sfr_rdata_r <= {rd_byte(addr_hi), rd_byte(sfr_addr)};
      end else begin
        sfr_rdata_r <= {8'h00, rd_byte(sfr_addr)};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign sfr_rdata      = sfr_rdata_r;
  assign irq_req        = irq_req_r;
  assign irq_src        = irq_src_r;
  assign irq_prio       = irq_prio_r;
  assign status_word    = status_word_r;
  assign psw_push_valid = psw_push_valid_r;
  assign psw_push_data  = psw_push_data_r;
  assign request_flags  = request_flag_r;

endmodule

// >>> irq_ctl_checker.sv
`timescale 1ns/1ps
module irq_ctl_checker (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       ei_instr,
  input wire logic       brk_instr,
  input wire logic       return_from_int_instr_instr,
  input wire logic       return_from_break_instr_instr,
  input wire logic       pop_psw_instr,
  input wire logic       push_psw_instr,
  input wire logic [7:0] psw_pop_data,
  input wire logic       irq_ack,
  input wire logic       irq_req,
  input wire logic       irq_prio,
  input wire logic [7:0] status_word,
  input wire logic       psw_push_valid,
  input wire logic [7:0] psw_push_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic take;
  logic pop;
  // accepted acknowledge and any status restore
  assign take = irq_req && irq_ack;
  assign pop  = return_from_int_instr_instr || return_from_break_instr_instr || pop_psw_instr;
  ////////////////////////////////////////////////////////////////////////
  a_ack_clear_ie: assert property (take |=> !status_word[7]) else $error("ack left enable set");
  a_ack_isp_copy: assert property (take |=> status_word[1] == $past(irq_prio))
    else $error("ack did not copy priority");
  a_ack_push_old: assert property (take |=> psw_push_valid && psw_push_data == $past(status_word))
    else $error("ack push wrong");
  a_brk_push_clear: assert property (brk_instr |=> psw_push_valid && !status_word[7])
    else $error("break push wrong");
  a_ei_sets_ie: assert property (ei_instr && !take && !brk_instr && !pop |=> status_word[7])
    else $error("enable instr failed");
  a_pop_restore: assert property (pop && !take && !brk_instr |=> status_word == $past(psw_pop_data))
    else $error("restore wrong");
  a_push_instr_save: assert property (push_psw_instr |=> psw_push_valid && psw_push_data == $past(status_word))
    else $error("push instr wrong");
  a_req_needs_ie: assert property (irq_req |-> $past(status_word[7])) else $error("request while disabled");
  a_low_needs_isp: assert property (irq_req && irq_prio |-> $past(status_word[1]))
    else $error("low request while high in service");
endmodule
bind irq_ctl irq_ctl_checker chk (.clk, .resetn, .ei_instr, .brk_instr, .return_from_int_instr_instr, .return_from_break_instr_instr, .pop_psw_instr,
  .push_psw_instr, .psw_pop_data, .irq_ack, .irq_req, .irq_prio, .status_word, .psw_push_valid, .psw_push_data);

// >>> core_ack_model.sv
`timescale 1ns/1ps
module core_ack_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       irq_req,
  input  wire logic [4:0] irq_src,
  input  wire logic [1:0] delay,
  output logic            irq_ack,
  output logic      [4:0] acked_src
);
  logic [1:0] wait_r;
  // acknowledge a pending request after delay cycles, one pulse each
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_ack   <= 1'b0;
      wait_r    <= 2'h0;
      acked_src <= 5'h00;
    end else if (irq_ack) begin
      irq_ack   <= 1'b0;
      wait_r    <= 2'h0;
      acked_src <= irq_src;
    end else if (irq_req) begin
      if (wait_r >= delay) irq_ack <= 1'b1;
      else wait_r <= wait_r + 2'h1;
    end else begin
      wait_r <= 2'h0;
    end
  end
endmodule

// >>> irq_ctl_tb.sv
`timescale 1ns/1ps
module irq_ctl_tb;
  typedef struct {logic wr; logic wd; logic [15:0] a; logic [15:0] d;} row_t;
  logic clk = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0, sfr_word = 0, sfr_bit = 0;
  logic ei = 0, di = 0, break_instr = 0, return_from_int_instr = 0, return_from_break_instr = 0, popi = 0, pushi = 0, wdog = 0;
  logic [2:0]  bidx = 0;
  logic [15:0] sfr_addr = 0, sfr_wdata = 0, rdata;
  logic [7:0]  pop_d = 0, sw, push_d;
  logic [23:0] preq = 0, flags;
  logic [3:0]  pin = 0;
  logic [4:0]  src, acked;
  logic [1:0]  dly = 0;
  logic        req, ack, prio, push_v;
  int miscompares = 0, num_checks = 0, cycles = 0;
  row_t rows[$] = '{
    '{0,0,16'hFF48,16'h0000}, '{0,0,16'hFF49,16'h0000}, '{0,1,16'hFFE4,16'hFFFF}, '{0,0,16'hFFE6,16'h00FF},
    '{0,1,16'hFFE8,16'hFFFF}, '{0,0,16'hFFEA,16'h00FF}, '{0,0,16'hFF1E,16'h0002},
    '{1,0,16'hFF48,16'h00FF}, '{0,0,16'hFF48,16'h00F0}, '{1,0,16'hFF49,16'h00FF}, '{0,0,16'hFF49,16'h000F},
    '{1,1,16'hFFE4,16'h1634}, '{0,0,16'hFFE4,16'h0034}, '{0,0,16'hFFE5,16'h0016}, '{1,0,16'hFFE6,16'h00A5},
    '{0,0,16'hFFE6,16'h00A5}, '{1,1,16'hFFE8,16'h5678}, '{0,1,16'hFFE8,16'h5678}, '{1,0,16'hFF00,16'h00AA},
    '{0,0,16'hFF00,16'h0000}};

  irq_ctl dut (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_word(sfr_word), .sfr_bit(sfr_bit), .sfr_bit_idx(bidx), .sfr_wdata(sfr_wdata), .sfr_rdata(rdata),
    .ei_instr(ei), .di_instr(di), .brk_instr(break_instr), .return_from_int_instr_instr(return_from_int_instr), .return_from_break_instr_instr(return_from_break_instr), .pop_psw_instr(popi),
    .push_psw_instr(pushi), .psw_pop_data(pop_d), .irq_ack(ack), .periph_req(preq), .port0_pin(pin),
    .wdog_mode1(wdog), .irq_req(req), .irq_src(src), .irq_prio(prio), .status_word(sw),
    .psw_push_valid(push_v), .psw_push_data(push_d), .request_flags(flags));
  core_ack_model core (.clk(clk), .resetn(resetn), .irq_req(req), .irq_src(src), .delay(dly), .irq_ack(ack),
    .acked_src(acked));

  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  // one register access, strobe held for one edge
  task automatic acc(logic wr, logic wd, logic bt, logic [2:0] bi, logic [15:0] a, logic [15:0] d);
    @(negedge clk);
    {sfr_addr, sfr_wr, sfr_rd, sfr_word, sfr_bit, bidx, sfr_wdata} = {a, wr, !wr, wd, bt, bi, d};
    @(negedge clk);
    {sfr_wr, sfr_rd, sfr_word, sfr_bit} = 4'h0;
    @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // let the core take one pending request, then disable again
  task automatic pass();
    pulse(ei);
    tick(8);
    pulse(di);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(20);
    resetn = 1'b1;
    foreach (rows[i]) begin
      acc(rows[i].wr, rows[i].wd, 1'b0, 3'h0, rows[i].a, rows[i].d);
      if (!rows[i].wr) check(rdata, rows[i].d);
    end
    acc(1, 0, 1, 3'h6, 16'hFFE6, 16'h0001);
    acc(0, 0, 0, 3'h0, 16'hFFE6, 16'h0000);
    check(rdata, 16'h00E5);
    acc(1, 0, 0, 3'h0, 16'hFFE4, 16'h00E1);
    acc(1, 0, 0, 3'h0, 16'hFFE8, 16'h00FF);
    // every edge mode on pin 0
    for (int m = 0; m < 4; m++) begin
      acc(1, 0, 0, 3'h0, 16'hFF48, 16'(m[1]) << 4);
      acc(1, 0, 0, 3'h0, 16'hFF49, 16'(m[0]));
      pin[0] = 1'b1;
      tick(8);
      check(16'(flags[1]), 16'(m[1]));
      pass();
      check(16'(flags[1]), 16'h0);
      pin[0] = 1'b0;
      tick(8);
      check(16'(flags[1]), 16'(m[0]));
      pass();
    end
    // all pins at once, ties taken in index order by a slow core
    dly = 2'h3;
    acc(1, 0, 0, 3'h0, 16'hFF48, 16'h00F0);
    pin = 4'hF;
    tick(8);
    check(16'(flags[4:1]), 16'hF);
    for (int s = 1; s < 5; s++) begin
      pass();
      check(16'(acked), 16'(s));
    end
    acc(1, 0, 0, 3'h0, 16'hFF48, 16'h0000);
    acc(1, 0, 0, 3'h0, 16'hFF49, 16'h0000);
    dly = 2'h0;
    // high beats low, then low held off while high in service
    acc(1, 0, 0, 3'h0, 16'hFFE8, 16'h00FB);
    @(negedge clk) preq = 24'h000006;
    @(negedge clk) preq = 24'h0;
    pass();
    check(16'(acked), 16'h2);
    check(16'(sw[1]), 16'h0);
    pulse(ei);
    tick(8);
    check(16'({req, flags[1]}), 16'h1);
    pop_d = 8'h82;
    pulse(popi);
    tick(8);
    check(16'(acked), 16'h1);
    check(16'(sw), 16'h0002);
    pulse(break_instr);
    check(16'({push_v, push_d}), 16'h0102);
    pulse(pushi);
    pulse(return_from_break_instr);
    pulse(return_from_int_instr);
    // watchdog mask reads undefined, chosen as 0
    wdog = 1'b1;
    acc(1, 0, 1, 3'h0, 16'hFFE8, 16'h0001);
    acc(0, 0, 0, 3'h0, 16'hFFE4, 16'h0000);
    check(rdata, 16'h00E0);
    wdog = 1'b0;
    acc(0, 0, 0, 3'h0, 16'hFFE4, 16'h0000);
    check(rdata, 16'h00E1);
    // masked source waits until its mask bit is cleared
    acc(1, 0, 1, 3'h7, 16'hFF1E, 16'h0001);
    @(negedge clk) preq = 24'h000020;
    @(negedge clk) preq = 24'h0;
    tick(6);
    check(16'({req, flags[5]}), 16'h1);
    acc(1, 0, 1, 3'h5, 16'hFFE4, 16'h0000);
    tick(6);
    check(16'(acked), 16'h5);
    check(16'(sw[7]), 16'h0);
    // shared pin masked before its level is driven low
    acc(1, 0, 1, 3'h1, 16'hFFE4, 16'h0001);
    acc(1, 0, 0, 3'h0, 16'hFF49, 16'h0001);
    pulse(ei);
    pin[0] = 1'b0;
    tick(8);
    check(16'({req, flags[1]}), 16'h1);
    // mid-run reset returns every register to its reset value
    resetn = 1'b0;
    tick(2);
    check(16'(sw), 16'h0002);
    check(16'({push_v, req, |flags}), 16'h0);
    resetn = 1'b1;
    acc(0, 1, 0, 3'h0, 16'hFFE4, 16'h0000);
    check(rdata, 16'hFFFF);
    acc(0, 1, 0, 3'h0, 16'hFFE8, 16'h0000);
    check(rdata, 16'hFFFF);
    acc(0, 0, 0, 3'h0, 16'hFF49, 16'h0000);
    check(rdata, 16'h0000);
    conclude();
  end
endmodule
